// File: verilog/otm_pkg.sv
// constants for the over-range and timestamp monitor
// assumes one 100 MHz device clock and an AXI4-Lite register port
package otm_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned MAG_W = 11;
  localparam int unsigned CMP_W = 8;
  localparam int unsigned HOLD_W = 11;
  localparam logic [10:0] MAG_MAX = 11'h7ff;
  localparam logic [11:0] SAMPLE_MOST_NEG = 12'h800;
  localparam logic [10:0] HOLD_BASE = 11'h008;
  // register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_THRESH = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // control field positions
  localparam int unsigned CTRL_OVERRANGE_DETECT_ENABLE = 0;
  localparam int unsigned CTRL_TRIG_OUT_EN = 1;
  localparam int unsigned CTRL_TRIG_SRC_LO = 2;
  localparam int unsigned CTRL_TS_EN = 4;
  localparam int unsigned CTRL_RECV_EN = 5;
  localparam int unsigned CTRL_HOLD_LO = 8;
  localparam logic [1:0] TRIG_SRC_TIMESTAMP = 2'h3;
  // status field positions
  localparam int unsigned STAT_OVR_LO = 0;
  localparam int unsigned STAT_SRC_LO = 4;
  localparam int unsigned STAT_PD = 6;
  localparam int unsigned STAT_TRIG = 7;
  // reset values
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [7:0] THRESH_RESET = 8'hff;
  // sampling clock source codes
  typedef enum logic [1:0] {
    OTM_SRC_DIRECT_DIFF = 2'b00,
    OTM_SRC_PLL_DIFF = 2'b01,
    OTM_SRC_PLL_SE = 2'b10
  } otm_src_e;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : otm_pkg

// File: verilog/otm_top.sv
// over-range detector, timestamp marker and clock source selection
// assumes samples arrive every enabled cycle from logic on aclk; pins are asynchronous
// Behaviour
// R1 - compare upper 8 bits of each 12-bit sample magnitude with threshold
// R2 - one threshold shared by all channels
// R3 - 11-bit magnitude, most negative sample saturates to 2047
// R4 - comparison value is top eight magnitude bits, 2032 gives 254
// R5 - detection works only while detection enable is 1
// R6 - comparison at or above threshold sets channel status, else zero
// R7 - one over-range output pin per channel, A to D
// R8 - output held 8 to 1024 cycles after last event, event restarts count
// R9 - software should set threshold near full scale; downstream manages gain
// R10 - retimed trigger echoed out when output enabled and source is 3
// R11 - timestamp enable puts retimed trigger into each link word LSB
// R12 - 12-bit link word: trigger bit 0, truncated sample bits 11:1
// R13 - async trigger sampled with same latency as samples
// R14 - software enables trigger receiver before any timestamp use
// R15 - pll enable picks pll; reference select picks single-ended reference
// R16 - both pins low gives direct differential clock; single-ended needs pll
// R17 - power-down pin powers down and disables all clock outputs
// R18 - sync reference captured on the selected clock input
// R19 - selected sampling clock also clocks digital logic and serializer
// R20 - detection disabled holds outputs low and clears counters
// R21 - each channel counter runs independently
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module otm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [otm_pkg::SAMPLE_W-1:0] sample_a,
  input wire logic [otm_pkg::SAMPLE_W-1:0] sample_b,
  input wire logic [otm_pkg::SAMPLE_W-1:0] sample_c,
  input wire logic [otm_pkg::SAMPLE_W-1:0] sample_d,
  input wire logic trigger_input,
  input wire logic pll_enable_pin,
  input wire logic pll_reference_select,
  input wire logic power_down_pin,
  input wire logic sysref_in,
  output logic overrange_out_a,
  output logic overrange_out_b,
  output logic overrange_out_c,
  output logic overrange_out_d,
  output logic trigger_output,
  output logic [otm_pkg::SAMPLE_W-1:0] link_word_a,
  output logic [otm_pkg::SAMPLE_W-1:0] link_word_b,
  output logic [otm_pkg::SAMPLE_W-1:0] link_word_c,
  output logic [otm_pkg::SAMPLE_W-1:0] link_word_d,
  output logic [1:0] sampling_clock_source,
  output logic single_ended_clock_usable,
  output logic sysref_from_single_ended,
  output logic sysref_captured,
  output logic device_powered_down,
  output logic clock_outputs_enable,
  output logic reference_clock_out_enable
);
  import otm_pkg::*;
  // ==========================================================
  // pin synchronisers
  logic [4:0] pins_in, sync1_r, sync1_nxt, sync2_r, sync2_nxt;
  logic trig_s, pll_en_s, ref_se_s, pd_s, sysref_s;
  assign pins_in = {sysref_in, power_down_pin, pll_reference_select, pll_enable_pin,
                    trigger_input};
  assign trig_s = sync2_r[0];
  assign pll_en_s = sync2_r[1];
  assign ref_se_s = sync2_r[2];
  assign pd_s = sync2_r[3];
  assign sysref_s = sync2_r[4];
  always_comb begin
    sync1_nxt = pins_in;
    sync2_nxt = sync1_r;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else if (clk_en) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end
  // ==========================================================
  // register bus
  logic [10:0] ctrl_r, ctrl_nxt;
  logic [7:0] thresh_r, thresh_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [3:0] awaddr_r, awaddr_nxt, wstrb_r, wstrb_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, status_word;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [NUM_CH-1:0] ovr_r;
  logic overrange_detect_enable, ts_en, recv_en, trig_out_on;
  logic [2:0] hold_sel;
  assign overrange_detect_enable = ctrl_r[CTRL_OVERRANGE_DETECT_ENABLE];
  assign ts_en = ctrl_r[CTRL_TS_EN];
  assign recv_en = ctrl_r[CTRL_RECV_EN];
  assign hold_sel = ctrl_r[CTRL_HOLD_LO +: 3];
  assign trig_out_on = ctrl_r[CTRL_TRIG_OUT_EN]
                       && (ctrl_r[CTRL_TRIG_SRC_LO +: 2] == TRIG_SRC_TIMESTAMP); // R10
  assign s_axi_awready = clk_en && !aw_held_r && !bvalid_r;
  assign s_axi_wready = clk_en && !w_held_r && !bvalid_r;
  assign s_axi_arready = clk_en && !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  always_comb begin
    ctrl_nxt = ctrl_r;
    thresh_nxt = thresh_r;
    aw_held_nxt = aw_held_r;
    awaddr_nxt = awaddr_r;
    w_held_nxt = w_held_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    // commit once both halves are held
    if (aw_held_r && w_held_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case ({awaddr_r[3:2], 2'b00})
        ADDR_CTRL: begin
          if (wstrb_r[0]) ctrl_nxt[7:0] = wdata_r[7:0];
          if (wstrb_r[1]) ctrl_nxt[10:8] = wdata_r[10:8];
        end
        ADDR_THRESH: if (wstrb_r[0]) thresh_nxt = wdata_r[7:0]; // R2
        ADDR_STATUS: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_DECERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        ADDR_CTRL: rdata_nxt = {21'h0, ctrl_r};
        ADDR_THRESH: rdata_nxt = {24'h000000, thresh_r};
        ADDR_STATUS: rdata_nxt = status_word;
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_DECERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
      thresh_r <= THRESH_RESET;
      aw_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      thresh_r <= thresh_nxt;
      aw_held_r <= aw_held_nxt;
      awaddr_r <= awaddr_nxt;
      w_held_r <= w_held_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  // ==========================================================
  // over-range detection per channel
  logic [SAMPLE_W-1:0] samp [NUM_CH];
  logic [HOLD_W-1:0] hold_len;
  assign samp[0] = sample_a;
  assign samp[1] = sample_b;
  assign samp[2] = sample_c;
  assign samp[3] = sample_d;
  assign hold_len = HOLD_BASE << hold_sel; // R8
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [MAG_W-1:0] mag;
    logic [SAMPLE_W-1:0] neg;
    logic [HOLD_W-1:0] cnt_r, cnt_nxt;
    logic hit, out_nxt;
    assign neg = ~samp[ch] + 12'h001;
    always_comb begin
      if (!samp[ch][SAMPLE_W-1]) begin
        mag = samp[ch][MAG_W-1:0]; // R1
      end else if (samp[ch] == SAMPLE_MOST_NEG) begin
        mag = MAG_MAX; // R3
      end else begin
        mag = neg[MAG_W-1:0];
      end
    end
    assign hit = overrange_detect_enable && (mag[MAG_W-1 -: CMP_W] >= thresh_r); // R4 R5 R6
    always_comb begin
      if (!overrange_detect_enable) begin
        cnt_nxt = 11'h000; // R20
      end else if (hit) begin
        cnt_nxt = hold_len; // R8
      end else if (cnt_r != 11'h000) begin
        cnt_nxt = cnt_r - 11'h001;
      end else begin
        cnt_nxt = cnt_r;
      end
      out_nxt = (cnt_nxt != 11'h000);
    end
    always_ff @(posedge aclk) begin // R21
      if (!aresetn) begin
        cnt_r <= 11'h000;
        ovr_r[ch] <= 1'b0;
      end else if (clk_en) begin
        cnt_r <= cnt_nxt;
        ovr_r[ch] <= out_nxt;
      end
    end
  end
  assign overrange_out_a = ovr_r[0]; // R7
  assign overrange_out_b = ovr_r[1];
  assign overrange_out_c = ovr_r[2];
  assign overrange_out_d = ovr_r[3];
  // ==========================================================
  // timestamp path, samples delayed to match the trigger synchroniser
  logic [SAMPLE_W-1:0] dly1_r [NUM_CH], dly2_r [NUM_CH], link_r [NUM_CH], link_nxt [NUM_CH];
  logic trig_rx, trig_out_r, trig_out_nxt;
  assign trig_rx = trig_s && recv_en; // R14
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (ts_en) begin
        link_nxt[i] = {dly2_r[i][SAMPLE_W-1:1], trig_rx}; // R11 R12 R13
      end else begin
        link_nxt[i] = dly2_r[i];
      end
    end
    trig_out_nxt = trig_rx && trig_out_on && !pd_s; // R10 R17
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dly1_r[i] <= 12'h000;
        dly2_r[i] <= 12'h000;
        link_r[i] <= 12'h000;
      end
      trig_out_r <= 1'b0;
    end else if (clk_en) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dly1_r[i] <= samp[i];
        dly2_r[i] <= dly1_r[i];
        link_r[i] <= link_nxt[i];
      end
      trig_out_r <= trig_out_nxt;
    end
  end
  assign link_word_a = link_r[0];
  assign link_word_b = link_r[1];
  assign link_word_c = link_r[2];
  assign link_word_d = link_r[3];
  assign trigger_output = trig_out_r;
  // ==========================================================
  // clock source selection and power down
  logic [1:0] src_r, src_nxt;
  logic [4:0] clkst_r, clkst_nxt;
  always_comb begin
    if (pll_en_s && ref_se_s) begin
      src_nxt = OTM_SRC_PLL_SE; // R15
    end else if (pll_en_s) begin
      src_nxt = OTM_SRC_PLL_DIFF;
    end else begin
      src_nxt = OTM_SRC_DIRECT_DIFF; // R16
    end
    clkst_nxt[0] = pll_en_s; // R16
    clkst_nxt[1] = pll_en_s && ref_se_s; // R18
    clkst_nxt[2] = sysref_s; // R18
    clkst_nxt[3] = pd_s; // R17
    clkst_nxt[4] = pll_en_s && !pd_s; // R17
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_r <= OTM_SRC_DIRECT_DIFF;
      clkst_r <= 5'h00;
    end else if (clk_en) begin
      src_r <= src_nxt; // R19
      clkst_r <= clkst_nxt;
    end
  end
  assign sampling_clock_source = src_r;
  assign single_ended_clock_usable = clkst_r[0];
  assign sysref_from_single_ended = clkst_r[1];
  assign sysref_captured = clkst_r[2];
  assign device_powered_down = clkst_r[3];
  assign clock_outputs_enable = !clkst_r[3];
  assign reference_clock_out_enable = clkst_r[4];
  assign status_word = {24'h000000, trig_rx, clkst_r[3], src_r, ovr_r};
endmodule : otm_top

// File: testbench/otm_gain_model.sv
// downstream gain-control model watching the over-range pins
// assumes the over-range pins are registered on aclk
`timescale 1ns/10ps
module otm_gain_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] overrange_bits,
  output logic [2:0] gain
);
  // ========
  // gain steps down on a new over-range, back up after quiet
  logic any_r, any_nxt;
  logic [3:0] quiet_r, quiet_nxt;
  logic [2:0] gain_r, gain_nxt;
  assign gain = gain_r;
  always_comb begin
    any_nxt = |overrange_bits;
    quiet_nxt = any_nxt ? 4'h0 : quiet_r + 4'h1;
    gain_nxt = gain_r;
    if (any_nxt && !any_r && gain_r != 3'h0) gain_nxt = gain_r - 3'h1;
    else if (quiet_r == 4'hf && gain_r != 3'h7) gain_nxt = gain_r + 3'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      any_r <= 1'b0;
      quiet_r <= 4'h0;
      gain_r <= 3'h7;
    end else begin
      any_r <= any_nxt;
      quiet_r <= quiet_nxt;
      gain_r <= gain_nxt;
    end
  end
endmodule : otm_gain_model

// File: testbench/otm_top_assertions.sv
// assertions on the over-range monitor top ports
// assumes clk_en high and whole-word register writes
`timescale 1ns/10ps
module otm_top_assertions
  import otm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic trigger_input,
  input wire logic pll_enable_pin,
  input wire logic pll_reference_select,
  input wire logic power_down_pin,
  input wire logic overrange_out_a,
  input wire logic overrange_out_b,
  input wire logic overrange_out_c,
  input wire logic overrange_out_d,
  input wire logic trigger_output,
  input wire logic [SAMPLE_W-1:0] link_word_a,
  input wire logic [1:0] sampling_clock_source,
  input wire logic device_powered_down,
  input wire logic clock_outputs_enable
);
  // ========
  // shadow of control and threshold, pulse counter for channel a
  logic [10:0] ctl_r, ctl_nxt, cnt_r, cnt_nxt;
  logic [7:0] th_r, th_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0] aa_r, aa_nxt;
  logic [1:0] up_r, up_nxt;
  logic bv_r, cm, hit_a, trig_ok;
  function automatic logic [7:0] cmpv(input logic [11:0] s);
    logic [10:0] m;
    m = s[11] ? 11'(-s) : s[10:0];
    if (s == SAMPLE_MOST_NEG) m = MAG_MAX;
    return m[10:3];
  endfunction : cmpv
  always_comb begin
    aa_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aa_r;
    wd_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wd_r;
    cm = s_axi_bvalid && !bv_r && s_axi_bresp == RESP_OKAY;
    ctl_nxt = (cm && aa_r == ADDR_CTRL) ? wd_r[10:0] : ctl_r;
    th_nxt = (cm && aa_r == ADDR_THRESH) ? wd_r[7:0] : th_r;
    hit_a = ctl_nxt[0] && cmpv(sample_a) >= th_nxt;
    trig_ok = ctl_nxt[5] && ctl_nxt[1] && ctl_nxt[3:2] == TRIG_SRC_TIMESTAMP && !power_down_pin;
    cnt_nxt = (cnt_r != 11'h000) ? cnt_r - 11'h001 : cnt_r;
    if (hit_a) cnt_nxt = HOLD_BASE << ctl_nxt[10:8];
    if (!ctl_nxt[0]) cnt_nxt = 11'h000;
    up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= CTRL_RESET;
      th_r <= THRESH_RESET;
      aa_r <= 4'h0;
      wd_r <= 32'h0;
      bv_r <= 1'b0;
      cnt_r <= 11'h000;
      up_r <= 2'h0;
    end else begin
      ctl_r <= ctl_nxt;
      th_r <= th_nxt;
      aa_r <= aa_nxt;
      wd_r <= wd_nxt;
      bv_r <= s_axi_bvalid;
      cnt_r <= cnt_nxt;
      up_r <= up_nxt;
    end
  end
  // ========
  // properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_trig_on;
    (trigger_input && trig_ok) [*5];
  endsequence
  sequence s_stamp_on;
    (trigger_input && ctl_nxt[4] && ctl_nxt[5]) [*5];
  endsequence
  property p_hold_a;
    overrange_out_a == (cnt_r != 11'h000);
  endproperty
  property p_clr;
    !ctl_nxt[0] |=> !(overrange_out_a || overrange_out_b || overrange_out_c || overrange_out_d);
  endproperty
  property p_pd;
    power_down_pin [*4] |-> device_powered_down && !clock_outputs_enable;
  endproperty
  property p_src_se;
    (pll_enable_pin && pll_reference_select) [*4] |-> sampling_clock_source == OTM_SRC_PLL_SE;
  endproperty
  property p_src_dir;
    (!pll_enable_pin && !pll_reference_select) [*4] |->
      sampling_clock_source == OTM_SRC_DIRECT_DIFF;
  endproperty
  property p_link;
    (up_r == 2'h3 && $stable(sample_a)) [*4] |-> link_word_a[11:1] == sample_a[11:1];
  endproperty
  property p_trig;
    s_trig_on |-> trigger_output;
  endproperty
  property p_stamp;
    s_stamp_on |-> link_word_a[0];
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("pulse on a has wrong length");
  a_clr: assert property (p_clr) else $error("output high while disabled");
  a_pd: assert property (p_pd) else $error("power down not shown");
  a_src_se: assert property (p_src_se) else $error("single-ended source wrong");
  a_src_dir: assert property (p_src_dir) else $error("direct source wrong");
  a_link: assert property (p_link) else $error("link word sample bits wrong");
  a_trig: assert property (p_trig) else $error("trigger not echoed");
  a_stamp: assert property (p_stamp) else $error("timestamp bit missing");
endmodule : otm_top_assertions

// File: testbench/otm_top_bench.sv
// bench for the over-range monitor: register tasks, sample and pin stimulus
// assumes design, gain model and checker are compiled before it
`timescale 1ns/10ps
module otm_top_bench;
  import otm_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, trigger_input, pll_enable_pin, pll_reference_select;
  logic power_down_pin, sysref_in, overrange_out_a, overrange_out_b, overrange_out_c;
  logic overrange_out_d, trigger_output, single_ended_clock_usable, sysref_captured;
  logic sysref_from_single_ended, device_powered_down, clock_outputs_enable;
  logic reference_clock_out_enable;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, sampling_clock_source;
  logic [11:0] sample_a, sample_b, sample_c, sample_d, link_word_a;
  logic [2:0] gain;
  int n_errors, num_checks, n;
  otm_top dut (
    .aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_a, .sample_b,
    .sample_c, .sample_d, .trigger_input, .pll_enable_pin, .pll_reference_select,
    .power_down_pin, .sysref_in, .overrange_out_a, .overrange_out_b, .overrange_out_c,
    .overrange_out_d, .trigger_output, .link_word_a, .link_word_b(), .link_word_c(),
    .link_word_d(), .sampling_clock_source, .single_ended_clock_usable,
    .sysref_from_single_ended, .sysref_captured, .device_powered_down,
    .clock_outputs_enable, .reference_clock_out_enable
  );
  otm_gain_model u_far (.aclk, .aresetn, .gain,
    .overrange_bits({overrange_out_d, overrange_out_c, overrange_out_b, overrange_out_a}));
  // ========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [2:0] h;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    h = 3'h0;
    while (!h[0]) begin
      @(negedge aclk);
      h = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
      r = s_axi_bresp;
      @(posedge aclk);
      if (h[2]) s_axi_awvalid <= 1'b0;
      if (h[1]) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [1:0] h;
    logic [33:0] q;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    h = 2'h0;
    while (!h[0]) begin
      @(negedge aclk);
      h = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
      q = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (h[1]) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", e, q[31:0]);
    chk("rresp", {30'h0, er}, {30'h0, q[33:32]});
  endtask : rd
  task automatic pulse_a;
    @(posedge aclk);
    sample_a <= 12'h7f0;
    @(posedge aclk);
    sample_a <= 12'h000;
  endtask : pulse_a
  task automatic hit(input logic [7:0] th, input logic [3:0] e);
    wr(ADDR_THRESH, {24'h0, th}, RESP_OKAY);
    sample_a <= 12'h7f0;
    sample_b <= 12'h810;
    sample_c <= 12'h800;
    sample_d <= 12'h7ef;
    @(posedge aclk);
    sample_a <= 12'h000;
    sample_b <= 12'h000;
    sample_c <= 12'h000;
    sample_d <= 12'h000;
    @(negedge aclk);
    chk("ovr", {28'h0, e},
      {28'h0, overrange_out_d, overrange_out_c, overrange_out_b, overrange_out_a});
    repeat (12) @(posedge aclk);
  endtask : hit
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // ========
  // clock, watchdog and tests
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {trigger_input, pll_enable_pin, pll_reference_select, power_down_pin, sysref_in} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    {sample_a, sample_b, sample_c, sample_d} = 48'h0;
    n_errors = 0;
    num_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_THRESH, 32'hff, RESP_OKAY);
    rd(4'hc, 32'h0, RESP_DECERR);
    wr(4'hc, 32'h1, RESP_DECERR);
    wr(ADDR_STATUS, 32'hff, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    $display("test registers done");
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    hit(8'hfe, 4'h7);
    chk("gain", 32'h6, {29'h0, gain});
    hit(8'hff, 4'h4);
    hit(8'hfd, 4'hf);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CTRL, {21'h0, k[2:0], 8'h01}, RESP_OKAY);
      pulse_a();
      n = 0;
      @(negedge aclk);
      while (overrange_out_a === 1'b1 && n < 2000) begin
        n++;
        @(negedge aclk);
      end
      chk("hold", 32'h8 << k, 32'(n));
    end
    wr(ADDR_CTRL, 32'h701, RESP_OKAY);
    pulse_a();
    repeat (5) @(posedge aclk);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    @(negedge aclk);
    chk("ovr_off", 32'h0, {31'h0, overrange_out_a});
    hit(8'hfd, 4'h0);
    $display("test over-range done");
    sample_a <= 12'h5a4;
    trigger_input <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, {26'h0, 2'b11, s[1:0], 2'b10}, RESP_OKAY);
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      chk("tout", {31'h0, s == 3}, {31'h0, trigger_output});
    end
    chk("link", 32'h5a5, {20'h0, link_word_a});
    rd(ADDR_STATUS, 32'h80, RESP_OKAY);
    power_down_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("pd", 32'h2, {30'h0, device_powered_down, clock_outputs_enable});
    chk("tout", 32'h0, {31'h0, trigger_output});
    @(posedge aclk);
    power_down_pin <= 1'b0;
    wr(ADDR_CTRL, 32'h10, RESP_OKAY);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("link", 32'h5a4, {20'h0, link_word_a});
    $display("test timestamp done");
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      pll_enable_pin <= i[1];
      pll_reference_select <= i[1] & i[0];
      sysref_in <= i[0];
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      chk("src", {30'h0, i[1] ? {i[0], !i[0]} : 2'b00}, {30'h0, sampling_clock_source});
      chk("clk", {28'h0, i[1], i[1] & i[0], i[0], i[1]}, {28'h0, single_ended_clock_usable,
        sysref_from_single_ended, sysref_captured, reference_clock_out_enable});
    end
    $display("test clocking done");
    repeat (300) @(posedge aclk);
    chk("gain", 32'h7, {29'h0, gain});
    wrap_up();
  end
endmodule : otm_top_bench
bind otm_top otm_top_assertions u_chk (.*);
